// ===== hw/program_space_access_unit.sv
// Program space address generation, table and constant-window access
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Summary of operation
// R1 - Program address bit 0 always zero
// R2 - Table address is page over effective address
// R3 - Page bit 7 selects configuration space
// R4 - Configuration space: reads only, implemented area
// R5 - Table accesses need no word alignment
// R6 - Low table ops reach bits 15:0
// R7 - High table ops reach bits 23:16
// R8 - Low byte read picks byte by select
// R9 - High word read zeroes upper byte
// R10 - High byte read of phantom returns zero
// R11 - Program counter steps two per word
// R12 - Window only when address bit 15, enabled
// R13 - Window address: zero, page, bits 14:0
// R14 - Window reads return low sixteen bits
// R15 - Software fills window words' upper byte uniformly
// R16 - Window read lengthens instruction by cycles
// R17 - Window disabled during table operations
// R18 - Outside repeat: moves one, others two
// R19 - Inside repeat: two at edges, else none
// R20 - Rows of 64 words, blocks of 512
// R21 - Table writes go to holding latches
// R22 - Byte select is effective address bit 0
module program_space_access_unit #(
   parameter logic [23:0] CFG_IMPL_BASE = 24'h80_0000,
   parameter logic [23:0] CFG_IMPL_LAST = 24'h80_07FE
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [1:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   input wire program_space_pkg::cpu_req_t CPU_REQ,
   output program_space_pkg::cpu_rsp_t CPU_RSP,
   output logic MEM_RD,
   output logic [23:0] MEM_ADDR,
   output logic MEM_CFG,
   input wire logic [23:0] MEM_RDATA,
   input wire logic [5:0] LATCH_IDX,
   output logic [23:0] LATCH_Q,
   output logic [23:0] ROW_ADDR,
   output logic [23:0] BLOCK_ADDR,
   output logic [23:0] NEXT_PC
);

   typedef struct packed {
      program_space_pkg::unit_state_t st;
      program_space_pkg::access_kind_t kind;
      logic byte_mode;
      logic sel;
      logic cw;
      logic [1:0] extra;
      logic [1:0] cnt;
      logic tbl_active;
      logic mem_rd;
      logic [23:0] mem_addr;
      logic mem_cfg;
      logic lat_we;
      logic [5:0] lat_idx;
      logic [23:0] lat_data;
      logic [2:0] lat_be;
      logic [7:0] table_page;
      logic [7:0] window_page;
      logic [15:0] core_control;
      logic refused_sticky;
      logic [15:0] reg_rdata;
      program_space_pkg::cpu_rsp_t rsp;
      logic [23:0] row_addr;
      logic [23:0] block_addr;
      logic [23:0] next_pc;
   } unit_t;

   unit_t s_reg;
   unit_t s_next;
   logic [23:0] latch_mem [program_space_pkg::ROW_WORDS];
   logic [23:0] latch_q_reg;

   // Table kinds share addressing; decoded in several places
   function automatic logic is_table(input program_space_pkg::access_kind_t k);
      return k inside {program_space_pkg::ACC_TRD_LO, program_space_pkg::ACC_TRD_HI,
                       program_space_pkg::ACC_TWR_LO, program_space_pkg::ACC_TWR_HI};
   endfunction

   function automatic logic is_write(input program_space_pkg::access_kind_t k);
      return k inside {program_space_pkg::ACC_TWR_LO, program_space_pkg::ACC_TWR_HI};
   endfunction

   // Penalty of a window read by instruction class and loop position
   function automatic logic [1:0] cw_penalty(input program_space_pkg::cpu_req_t r);
      if (r.in_repeat) begin
         return r.repeat_edge ? program_space_pkg::EXTRA_OTHER
                              : program_space_pkg::EXTRA_NONE; // see R19
      end
      return r.transfer_instr ? program_space_pkg::EXTRA_MOVE
                              : program_space_pkg::EXTRA_OTHER; // see R18
   endfunction

   logic accept;
   logic cw_hit;
   logic [23:0] tbl_addr;
   logic [23:0] cw_addr;
   logic [23:0] fetch_addr;
   logic cfg_impl;
   logic [15:0] status_word;

   // Address candidates for every access type
   always_comb begin
      accept = CPU_REQ.valid && (s_reg.st == program_space_pkg::ST_IDLE);
      fetch_addr = {1'b0, CPU_REQ.pc[22:1], 1'b0}; // see R1
      // Any effective address accepted; bit 0 only becomes the byte select
      tbl_addr = {s_reg.table_page, CPU_REQ.effective_address[15:1], 1'b0}; // see R2, R5, R22
      cw_addr = {1'b0, s_reg.window_page, CPU_REQ.effective_address[14:1], 1'b0}; // see R13
      // Window blocked while a table access is still in flight
      cw_hit = CPU_REQ.effective_address[15]
               && s_reg.core_control[program_space_pkg::CW_ENABLE_BIT]
               && !s_reg.tbl_active; // see R12, R17
      cfg_impl = (tbl_addr >= CFG_IMPL_BASE) && (tbl_addr <= CFG_IMPL_LAST);
      status_word = 16'h0000;
      status_word[program_space_pkg::STAT_REFUSED_BIT] = s_reg.refused_sticky;
      status_word[program_space_pkg::STAT_BUSY_BIT] = s_reg.rsp.busy;
      status_word[program_space_pkg::STAT_TABLE_BIT] = s_reg.tbl_active;
   end

   // Next state: register port, request intake, memory sequencing
   always_comb begin
      logic cfg;
      logic [23:0] p;
      cfg = 1'b0;
      p = MEM_RDATA;
      s_next = s_reg;
      s_next.mem_rd = 1'b0;
      s_next.lat_we = 1'b0;
      s_next.rsp.ack = 1'b0;
      s_next.reg_rdata = 16'h0000;

      // Register port; read data stands in the following cycle only
      if (REG_WR) begin
         unique case (REG_ADDR)
            program_space_pkg::OFS_TABLE_PAGE: s_next.table_page = REG_WDATA[7:0];
            program_space_pkg::OFS_WINDOW_PAGE: s_next.window_page = REG_WDATA[7:0];
            program_space_pkg::OFS_CORE_CONTROL: s_next.core_control = REG_WDATA;
            program_space_pkg::OFS_STATUS: begin
               if (REG_WDATA[program_space_pkg::STAT_REFUSED_BIT]) begin
                  s_next.refused_sticky = 1'b0;
               end
            end
         endcase
      end
      if (REG_RD) begin
         unique case (REG_ADDR)
            program_space_pkg::OFS_TABLE_PAGE: s_next.reg_rdata = {8'h00, s_reg.table_page};
            program_space_pkg::OFS_WINDOW_PAGE: s_next.reg_rdata = {8'h00, s_reg.window_page};
            program_space_pkg::OFS_CORE_CONTROL: s_next.reg_rdata = s_reg.core_control;
            program_space_pkg::OFS_STATUS: s_next.reg_rdata = status_word;
         endcase
      end

      unique case (s_reg.st)
         program_space_pkg::ST_IDLE: begin
            if (accept) begin
               s_next.st = program_space_pkg::ST_ISSUE;
               s_next.rsp.busy = 1'b1;
               s_next.rsp.refused = 1'b0;
               s_next.rsp.redirected = 1'b0;
               s_next.kind = CPU_REQ.kind;
               s_next.byte_mode = CPU_REQ.byte_mode;
               s_next.sel = CPU_REQ.effective_address[0]; // see R22
               s_next.cw = 1'b0;
               s_next.extra = program_space_pkg::EXTRA_NONE;
               s_next.tbl_active = is_table(CPU_REQ.kind); // see R17
               unique case (CPU_REQ.kind)
                  program_space_pkg::ACC_FETCH: begin
                     s_next.mem_rd = 1'b1;
                     s_next.mem_addr = fetch_addr;
                     s_next.mem_cfg = 1'b0;
                     s_next.next_pc = fetch_addr + program_space_pkg::PC_STEP; // see R11
                  end
                  program_space_pkg::ACC_DATA_RD: begin
                     if (cw_hit) begin
                        s_next.cw = 1'b1;
                        s_next.rsp.redirected = 1'b1;
                        s_next.mem_rd = 1'b1;
                        s_next.mem_addr = cw_addr;
                        s_next.mem_cfg = 1'b0;
                        s_next.extra = cw_penalty(CPU_REQ); // see R16
                     end
                  end
                  default: begin
                     cfg = s_reg.table_page[program_space_pkg::CFG_SPACE_BIT]; // see R3
                     s_next.mem_addr = tbl_addr;
                     s_next.mem_cfg = cfg;
                     s_next.row_addr = {tbl_addr[23:program_space_pkg::ROW_ADDR_LSB],
                                        7'h00}; // see R20
                     s_next.block_addr = {tbl_addr[23:program_space_pkg::BLOCK_ADDR_LSB],
                                          10'h000}; // see R20
                     if (is_write(CPU_REQ.kind)) begin
                        if (cfg) begin
                           // Config writes never reach the latches
                           s_next.rsp.refused = 1'b1; // see R4
                           s_next.refused_sticky = 1'b1;
                        end else begin
                           s_next.lat_we = 1'b1; // see R21
                           s_next.lat_idx = tbl_addr[6:1];
                           s_next.lat_data = {CPU_REQ.wdata[7:0], CPU_REQ.wdata};
                           s_next.lat_be = 3'b000;
                           if (CPU_REQ.kind == program_space_pkg::ACC_TWR_LO) begin
                              if (!CPU_REQ.byte_mode) begin
                                 s_next.lat_be = 3'b011; // see R6
                              end else if (CPU_REQ.effective_address[0]) begin
                                 s_next.lat_data[15:8] = CPU_REQ.wdata[7:0];
                                 s_next.lat_be = 3'b010;
                              end else begin
                                 s_next.lat_be = 3'b001;
                              end
                           end else if (!(CPU_REQ.byte_mode
                                          && CPU_REQ.effective_address[0])) begin
                              s_next.lat_be = 3'b100; // see R7
                           end
                        end
                     end else if (!cfg || cfg_impl) begin
                        s_next.mem_rd = 1'b1; // see R4
                     end else begin
                        s_next.rsp.refused = 1'b1;
                     end
                  end
               endcase
            end
         end
         program_space_pkg::ST_ISSUE: begin
            s_next.st = program_space_pkg::ST_CAPTURE;
         end
         program_space_pkg::ST_CAPTURE: begin
            // Memory answers one cycle after its read strobe
            if (!s_reg.rsp.refused && !is_write(s_reg.kind)) begin
               s_next.rsp.word = p;
               unique case (s_reg.kind)
                  program_space_pkg::ACC_TRD_LO: begin
                     if (!s_reg.byte_mode) begin
                        s_next.rsp.rdata = p[15:0]; // see R6
                     end else begin
                        s_next.rsp.rdata = {8'h00, s_reg.sel ? p[15:8] : p[7:0]}; // see R8
                     end
                  end
                  program_space_pkg::ACC_TRD_HI: begin
                     if (s_reg.byte_mode && s_reg.sel) begin
                        s_next.rsp.rdata = 16'h0000; // see R10
                     end else begin
                        s_next.rsp.rdata = {8'h00, p[23:16]}; // see R7, R9
                     end
                  end
                  program_space_pkg::ACC_DATA_RD: begin
                     s_next.rsp.rdata = s_reg.cw ? p[15:0] : 16'h0000; // see R14
                  end
                  default: begin
                     s_next.rsp.rdata = p[15:0];
                  end
               endcase
            end else begin
               s_next.rsp.rdata = 16'h0000;
               s_next.rsp.word = 24'h00_0000;
            end
            if (s_reg.extra != program_space_pkg::EXTRA_NONE) begin
               s_next.st = program_space_pkg::ST_WAIT;
               s_next.cnt = s_reg.extra; // see R16
            end else begin
               s_next.st = program_space_pkg::ST_IDLE;
               s_next.rsp.ack = 1'b1;
               s_next.rsp.busy = 1'b0;
               s_next.tbl_active = 1'b0;
            end
         end
         program_space_pkg::ST_WAIT: begin
            // Extra cycles of the window read are counted down here; no memory read is made
            s_next.cnt = s_reg.cnt - 2'h1;
            if (s_reg.cnt == 2'h1) begin
               s_next.st = program_space_pkg::ST_IDLE;
               s_next.rsp.ack = 1'b1;
               s_next.rsp.busy = 1'b0;
               s_next.tbl_active = 1'b0;
            end
         end
      endcase
   end

   // State register; everything clears on reset
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s_reg <= '0;
         s_reg.table_page <= program_space_pkg::TABLE_PAGE_RST;
         s_reg.window_page <= program_space_pkg::WINDOW_PAGE_RST;
         s_reg.core_control <= program_space_pkg::CORE_CONTROL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // Holding latches; contents undefined after reset, as in the array
   always_ff @(posedge CLK) begin
      if (s_reg.lat_we) begin
         for (int b = 0; b < 3; b++) begin
            if (s_reg.lat_be[b]) begin
               latch_mem[s_reg.lat_idx][b*8 +: 8] <= s_reg.lat_data[b*8 +: 8]; // see R21
            end
         end
      end
      latch_q_reg <= latch_mem[LATCH_IDX];
   end

   assign REG_RDATA = s_reg.reg_rdata;
   assign CPU_RSP = s_reg.rsp;
   assign MEM_RD = s_reg.mem_rd;
   assign MEM_ADDR = s_reg.mem_addr;
   assign MEM_CFG = s_reg.mem_cfg;
   assign LATCH_Q = latch_q_reg;
   assign ROW_ADDR = s_reg.row_addr;
   assign BLOCK_ADDR = s_reg.block_addr;
   assign NEXT_PC = s_reg.next_pc;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_addr_lsb_zero: assert property (MEM_RD |-> MEM_ADDR[0] == 1'b0) // see R1
      else $error("program address bit 0 not zero");
   a_fetch_addr: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_FETCH
      |=> MEM_RD && MEM_ADDR == {1'b0, $past(CPU_REQ.pc[22:1]), 1'b0}) // see R1
      else $error("fetch address wrong");
   a_table_addr: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_TRD_LO
      |=> MEM_ADDR[23:1] == {$past(s_reg.table_page), $past(CPU_REQ.effective_address[15:1])}
      && MEM_CFG == MEM_ADDR[23]) // see R2, R3
      else $error("table address or space wrong");
   a_cfg_no_write: assert property (accept && is_write(CPU_REQ.kind)
      && s_reg.table_page[program_space_pkg::CFG_SPACE_BIT]
      |=> !s_reg.lat_we ##2 CPU_RSP.ack && CPU_RSP.refused) // see R4
      else $error("config table write not refused");
   a_hi_phantom: assert property (CPU_RSP.ack && $past(s_reg.kind, 1) ==
      program_space_pkg::ACC_TRD_HI |-> CPU_RSP.rdata[15:8] == 8'h00) // see R9, R10
      else $error("phantom byte not zero");
   a_cw_addr: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_DATA_RD && cw_hit
      |=> MEM_RD && MEM_ADDR[23:15] == {1'b0, $past(s_reg.window_page)}) // see R12, R13
      else $error("window address wrong");
   a_cw_move_cost: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_DATA_RD
      && cw_hit && !CPU_REQ.in_repeat && CPU_REQ.transfer_instr
      |=> !CPU_RSP.ack [*3] ##1 CPU_RSP.ack) // see R18
      else $error("window move penalty not one cycle");
   a_cw_other_cost: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_DATA_RD
      && cw_hit && (CPU_REQ.repeat_edge || !CPU_REQ.in_repeat) && !CPU_REQ.transfer_instr
      |=> !CPU_RSP.ack [*4] ##1 CPU_RSP.ack) // see R18, R19
      else $error("window penalty not two cycles");
   a_cw_repeat_mid: assert property (accept && CPU_REQ.kind == program_space_pkg::ACC_DATA_RD
      && cw_hit && CPU_REQ.in_repeat && !CPU_REQ.repeat_edge |-> ##3 CPU_RSP.ack) // see R19
      else $error("mid repeat window read not single");
   a_cw_blocked: assert property (s_reg.cw && s_reg.st != program_space_pkg::ST_IDLE
      |-> !s_reg.tbl_active) // see R17
      else $error("window used during table access");

endmodule // program_space_access_unit

// ===== shared/program_space_pkg.sv
// Constants, types and carriers of the program space access unit
package program_space_pkg;

   // Register port map (word index on the register port)
   localparam logic [1:0] OFS_TABLE_PAGE = 2'h0;
   localparam logic [1:0] OFS_WINDOW_PAGE = 2'h1;
   localparam logic [1:0] OFS_CORE_CONTROL = 2'h2;
   localparam logic [1:0] OFS_STATUS = 2'h3;

   // Field positions and reset values
   localparam int CW_ENABLE_BIT = 2;
   localparam int CFG_SPACE_BIT = 7;
   localparam int STAT_REFUSED_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_TABLE_BIT = 2;
   localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
   localparam logic [7:0] WINDOW_PAGE_RST = 8'h00;
   localparam logic [15:0] CORE_CONTROL_RST = 16'h0000;

   // Program memory organisation
   localparam int ROW_WORDS = 64;
   localparam int ROW_BYTES = 192;
   localparam int BLOCK_WORDS = 512;
   localparam int BLOCK_BYTES = 1536;
   localparam int ROW_ADDR_LSB = 7;
   localparam int BLOCK_ADDR_LSB = 10;
   localparam logic [23:0] PC_STEP = 24'h00_0002;

   // Extra cycles for a constant-window read
   localparam logic [1:0] EXTRA_NONE = 2'h0;
   localparam logic [1:0] EXTRA_MOVE = 2'h1;
   localparam logic [1:0] EXTRA_OTHER = 2'h2;

   typedef enum logic [2:0] {
      ACC_FETCH = 3'h0,
      ACC_DATA_RD = 3'h1,
      ACC_TRD_LO = 3'h2,
      ACC_TRD_HI = 3'h3,
      ACC_TWR_LO = 3'h4,
      ACC_TWR_HI = 3'h5
   } access_kind_t;

   // Gray codes along idle, issue, capture, wait
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_CAPTURE = 2'b11,
      ST_WAIT = 2'b10
   } unit_state_t;

   typedef struct packed {
      logic valid;
      access_kind_t kind;
      logic byte_mode;
      logic [15:0] effective_address;
      logic [23:0] pc;
      logic [15:0] wdata;
      logic transfer_instr;
      logic in_repeat;
      logic repeat_edge;
   } cpu_req_t;

   typedef struct packed {
      logic ack;
      logic busy;
      logic [15:0] rdata;
      logic [23:0] word;
      logic redirected;
      logic refused;
   } cpu_rsp_t;

endpackage

// ===== tb/program_memory_model.sv
// Program memory model answering the access unit's read strobe
`timescale 1ns/1ps
module program_memory_model (
   input wire logic CLK,
   input wire logic MEM_RD,
   input wire logic [23:0] MEM_ADDR,
   input wire logic MEM_CFG,
   output logic [23:0] MEM_RDATA
);
   // Contents follow the address so every lane and space reads distinct
   function automatic logic [23:0] word_at(input logic [23:0] a, input logic c);
      logic [7:0] hi;
      // Constant pages keep a uniform upper byte in case they are executed
      hi = a[22] ? 8'hFF : (a[23:16] ^ a[7:0] ^ {c, 7'h00});
      return {hi, a[15:0] ^ 16'hA55A};
   endfunction

   initial MEM_RDATA = 24'h00_0000;

   // Data stand only in the cycle after the strobe; otherwise they toggle
   always @(posedge CLK) begin
      if (MEM_RD) begin
         MEM_RDATA <= word_at(MEM_ADDR, MEM_CFG);
      end else begin
         MEM_RDATA <= ~MEM_RDATA;
      end
   end
endmodule // program_memory_model

// ===== tb/program_space_access_unit_tb.sv
// Self-checking bench of the program space access unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module program_space_access_unit_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata, rv;
   program_space_pkg::cpu_req_t req = '0;
   program_space_pkg::cpu_rsp_t rsp;
   logic mem_rd, mem_cfg, rd_seen;
   logic [23:0] mem_addr, mem_rdata, latch_q, row_addr, block_addr, next_pc, p;
   logic [5:0] latch_idx = 6'h00;
   logic [2:0] mds [4] = '{3'b000, 3'b100, 3'b011, 3'b010};
   int ext [4] = '{2, 1, 2, 0};
   int fail_count = 0;
   int n_tests = 0;
   int lat;

   program_space_access_unit uut (.CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .CPU_REQ(req), .CPU_RSP(rsp), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
      .MEM_CFG(mem_cfg), .MEM_RDATA(mem_rdata), .LATCH_IDX(latch_idx), .LATCH_Q(latch_q),
      .ROW_ADDR(row_addr), .BLOCK_ADDR(block_addr), .NEXT_PC(next_pc));
   program_memory_model mem_model (.CLK(clk), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
      .MEM_CFG(mem_cfg), .MEM_RDATA(mem_rdata));

   // Expected memory contents, worked out independently of the model
   function automatic logic [23:0] pw(input logic [23:0] a, input logic c);
      return {a[22] ? 8'hFF : (a[23:16] ^ a[7:0] ^ {c, 7'h00}), a[15:0] ^ 16'hA55A};
   endfunction

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data are taken only in the cycle after the strobe
   task automatic rd(input logic [1:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   // One CPU access; lat counts edges after the accept edge up to ack
   task automatic acc(input program_space_pkg::access_kind_t k, input logic bm,
      input logic [15:0] ea, input logic [23:0] pc, input logic [15:0] wd,
      input logic [2:0] md);
      @(posedge clk);
      req <= '{1'b1, k, bm, ea, pc, wd, md[2], md[1], md[0]};
      @(posedge clk);
      req.valid <= 1'b0;
      lat = 0;
      #1 rd_seen = (mem_rd === 1'b1);
      `CHK("busy", 1'b1, rsp.busy)
      do begin
         @(posedge clk);
         #1 lat++;
         if (mem_rd === 1'b1) rd_seen = 1'b1;
      end while (rsp.ack !== 1'b1 && lat < 20);
   endtask

   task automatic lq(input logic [5:0] i);
      @(posedge clk);
      latch_idx <= i;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic t_regs();
      for (int i = 0; i < 4; i++) begin
         rd(i[1:0]);
         `CHK("reset reg", 16'h0000, rv)
      end
      wr(2'h0, 16'hA512);
      rd(2'h0);
      `CHK("table page", 16'h0012, rv)
      wr(2'h2, 16'hF0F3);
      rd(2'h2);
      `CHK("core control", 16'hF0F3, rv)
      // Read data stand one cycle only, then fall back to zero
      @(posedge clk);
      #1;
      `CHK("rdata drop", 16'h0000, reg_rdata)
   endtask

   // Odd counter with bit 23 set still fetches an aligned user word
   task automatic t_fetch();
      acc(program_space_pkg::ACC_FETCH, 1'b0, 16'h0000, 24'h81_2347, 16'h0000, 3'b000);
      `CHK("fetch addr", 24'h01_2346, mem_addr)
      `CHK("next pc", 24'h01_2348, next_pc)
      `CHK("fetch word", pw(24'h01_2346, 1'b0), rsp.word)
      `CHK("fetch strobe", 1'b1, rd_seen)
      `CHK("idle after ack", 1'b0, rsp.busy)
   endtask

   task automatic t_table();
      p = pw(24'h12_3456, 1'b0);
      wr(2'h0, 16'h0012);
      acc(program_space_pkg::ACC_TRD_LO, 1'b0, 16'h3457, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("table addr", 24'h12_3456, mem_addr)
      `CHK("user space", 1'b0, mem_cfg)
      `CHK("lo word", p[15:0], rsp.rdata)
      `CHK("latency", 2, lat)
      acc(program_space_pkg::ACC_TRD_LO, 1'b1, 16'h3457, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("lo byte1", {8'h00, p[15:8]}, rsp.rdata)
      acc(program_space_pkg::ACC_TRD_LO, 1'b1, 16'h3456, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("lo byte0", {8'h00, p[7:0]}, rsp.rdata)
      acc(program_space_pkg::ACC_TRD_HI, 1'b0, 16'h3456, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("hi word", {8'h00, p[23:16]}, rsp.rdata)
      acc(program_space_pkg::ACC_TRD_HI, 1'b1, 16'h3456, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("hi byte0", {8'h00, p[23:16]}, rsp.rdata)
      acc(program_space_pkg::ACC_TRD_HI, 1'b1, 16'h3457, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("phantom", 16'h0000, rsp.rdata)
   endtask

   // Lane writes into one latch, then a refused write to configuration space
   task automatic t_latch();
      wr(2'h0, 16'h0001);
      acc(program_space_pkg::ACC_TWR_LO, 1'b0, 16'h028A, 24'h00_0000, 16'hBEEF, 3'b000);
      `CHK("row addr", 24'h01_0280, row_addr)
      `CHK("block addr", 24'h01_0000, block_addr)
      acc(program_space_pkg::ACC_TWR_HI, 1'b1, 16'h028A, 24'h00_0000, 16'h0077, 3'b000);
      acc(program_space_pkg::ACC_TWR_LO, 1'b1, 16'h028B, 24'h00_0000, 16'h3311, 3'b000);
      acc(program_space_pkg::ACC_TWR_HI, 1'b1, 16'h028B, 24'h00_0000, 16'h0099, 3'b000);
      lq(6'h05);
      `CHK("latch", 24'h77_11EF, latch_q)
      wr(2'h0, 16'h0080);
      acc(program_space_pkg::ACC_TWR_LO, 1'b0, 16'h000A, 24'h00_0000, 16'h1234, 3'b000);
      `CHK("cfg write refused", 1'b1, rsp.refused)
      lq(6'h05);
      `CHK("latch kept", 24'h77_11EF, latch_q)
      rd(2'h3);
      `CHK("sticky flag", 1'b1, rv[0])
      wr(2'h3, 16'h0001);
      rd(2'h3);
      `CHK("flag cleared", 1'b0, rv[0])
   endtask

   task automatic t_cfg();
      acc(program_space_pkg::ACC_TRD_LO, 1'b0, 16'h0010, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("cfg space", 1'b1, mem_cfg)
      `CHK("cfg addr", 24'h80_0010, mem_addr)
      `CHK("cfg read", pw(24'h80_0010, 1'b1) & 24'h00_FFFF, {8'h00, rsp.rdata})
      `CHK("cfg ok", 1'b0, rsp.refused)
      acc(program_space_pkg::ACC_TRD_LO, 1'b0, 16'h1000, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("no fetch", 1'b0, rd_seen)
      `CHK("cfg gap", 1'b1, rsp.refused)
      `CHK("gap data", 16'h0000, rsp.rdata)
   endtask

   // Window reads in every timing case, then the cases that must not redirect
   task automatic t_window();
      wr(2'h0, 16'h0012);
      wr(2'h1, 16'h00DA);
      wr(2'h2, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         acc(program_space_pkg::ACC_DATA_RD, 1'b0, 16'h8123, 24'h00_0000, 16'h0000, mds[i]);
         `CHK("win latency", 2 + ext[i], lat)
         `CHK("win addr", 24'h6D_0122, mem_addr)
         `CHK("win data", pw(24'h6D_0122, 1'b0) & 24'h00_FFFF, {8'h00, rsp.rdata})
         `CHK("win hit", 1'b1, rsp.redirected)
      end
      acc(program_space_pkg::ACC_TRD_LO, 1'b0, 16'h8124, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("table over win", 24'h12_8124, mem_addr)
      `CHK("table no hit", 1'b0, rsp.redirected)
      acc(program_space_pkg::ACC_DATA_RD, 1'b0, 16'h0123, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("low half", 1'b0, rsp.redirected)
      `CHK("low latency", 2, lat)
      wr(2'h2, 16'h0000);
      acc(program_space_pkg::ACC_DATA_RD, 1'b0, 16'h8123, 24'h00_0000, 16'h0000, 3'b000);
      `CHK("disabled", 1'b0, rsp.redirected)
      `CHK("disabled data", 16'h0000, rsp.rdata)
   endtask

   // Cut a hang short well beyond the expected run length
   initial begin
      #(25 * 20000);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_fetch();
      t_table();
      t_latch();
      t_cfg();
      t_window();
      report_and_stop();
   end
endmodule // program_space_access_unit_tb
